// ### hw/rts_top.sv
`timescale 1ns/100ps
// trigger sequencer: decides when the recorder captures samples
module rts_top #(
  parameter int NSRC = 8,
  parameter int INTV_SRC = 7, // interval source index
  parameter int LW = 16 // recording length counter width
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  input wire logic [NSRC-1:0] src_cond, // source condition levels, pins
  input wire logic start_key, // operator start key, pin
  input wire logic stop_key, // operator stop key, pin
  input wire logic proc_done, // post processing finished, same clock
  output logic meas_q, // measuring
  output logic rec_q, // capture enable
  output logic dead_q, // start/stop dead-time span
  output logic irq
);
  // settings
  logic en_q; // trigger function on
  logic [1:0] mode_q;
  logic [1:0] tim_q;
  logic start_and_q;
  logic stop_and_q;
  logic [13:0] count_q;
  logic [NSRC-1:0] start_src_q;
  logic [NSRC-1:0] stop_src_q;
  logic [LW-1:0] len_q;
  logic [LW-1:0] pre_q;
  logic [rts_pkg::NEV-1:0] ist_q; // sticky interrupt status
  logic [rts_pkg::NEV-1:0] ien_q; // interrupt enables
  // sequencer
  rts_pkg::rts_state_t state_q;
  rts_pkg::rts_state_t prev_st_q;
  logic stop_pend_q; // first stop seen
  logic [LW-1:0] cnt_q; // pre or recording sample count
  logic [13:0] recs_q; // completed recordings
  // synchronised pins and key edges
  logic [NSRC-1:0] cond_s;
  logic start_s;
  logic stop_s;
  logic start_old_q;
  logic stop_old_q;
  logic start_p;
  logic stop_p;
  logic [NSRC-1:0] start_mask;
  logic [NSRC-1:0] stop_mask;
  logic start_fire;
  logic stop_fire;
  logic free_run;
  logic rec_end;
  logic last_rec;
  logic [rts_pkg::NEV-1:0] ev;

  // clamp a written count into the legal range
  function automatic logic [13:0] clamp_count(input logic [31:0] v);
    if (v < 32'(rts_pkg::COUNT_MIN)) begin
      return rts_pkg::COUNT_MIN;
    end else if (v > 32'(rts_pkg::COUNT_MAX)) begin
      return rts_pkg::COUNT_MAX;
    end
    return v[13:0];
  endfunction : clamp_count

  // pins cross into clk_sys through two flops
  rts_sync #(.W(NSRC + 2)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({src_cond, start_key, stop_key}),
    .q({cond_s, start_s, stop_s})
  );

  // key press edges
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      start_old_q <= 1'b0;
      stop_old_q <= 1'b0;
    end else begin
      start_old_q <= start_s;
      stop_old_q <= stop_s;
    end
  end
  assign start_p = start_s & ~start_old_q;
  assign stop_p = stop_s & ~stop_old_q;

  // interval source is only ever a start condition
  assign start_mask = start_src_q;
  assign stop_mask = stop_src_q & ~(NSRC'(1) << INTV_SRC);

  rts_comb #(.N(NSRC)) u_start (
    .clk_sys(clk_sys),
    .srst(srst),
    .cond(cond_s),
    .mask(start_mask),
    .use_and(start_and_q),
    .fire(start_fire)
  );
  rts_comb #(.N(NSRC)) u_stop (
    .clk_sys(clk_sys),
    .srst(srst),
    .cond(cond_s),
    .mask(stop_mask),
    .use_and(stop_and_q),
    .fire(stop_fire)
  );

  // function off or nothing enabled: record without waiting
  assign free_run = ~en_q | ((start_mask | stop_mask) == '0);
  // full length reached, or stop trigger under stop or start/stop timing
  assign rec_end = (state_q == rts_pkg::ST_REC) &&
                   ((cnt_q == len_q - LW'(1)) ||
                    (~free_run && tim_q != rts_pkg::TIM_START && stop_fire));
  // whether this recording ends the measurement
  assign last_rec = stop_pend_q || ~en_q ||
                    (mode_q == rts_pkg::MODE_SINGLE) ||
                    (mode_q == rts_pkg::MODE_COUNT &&
                     recs_q + 14'h0001 >= count_q);

  // register writes; settings are live
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_q <= rts_pkg::RST_EN;
      mode_q <= rts_pkg::RST_MODE;
      tim_q <= rts_pkg::RST_TIM;
      start_and_q <= 1'b0;
      stop_and_q <= 1'b0;
      count_q <= rts_pkg::RST_COUNT;
      start_src_q <= '0;
      stop_src_q <= '0;
      len_q <= LW'(rts_pkg::RST_LEN); // sized to the counter width
      pre_q <= LW'(rts_pkg::RST_PRE);
      ien_q <= '0;
    end else if (wr_stb) begin
      case (addr)
        rts_pkg::OFS_CTRL: begin
          en_q <= wr_data[rts_pkg::CTL_EN];
          mode_q <= wr_data[rts_pkg::CTL_MODE_LSB +: 2];
          tim_q <= wr_data[rts_pkg::CTL_TIM_LSB +: 2];
          start_and_q <= wr_data[rts_pkg::CTL_START_AND];
          stop_and_q <= wr_data[rts_pkg::CTL_STOP_AND];
        end
        rts_pkg::OFS_COUNT: count_q <= clamp_count(wr_data);
        rts_pkg::OFS_SRC: begin
          start_src_q <= wr_data[NSRC-1:0];
          stop_src_q <= wr_data[rts_pkg::SRC_STOP_LSB +: NSRC];
        end
        rts_pkg::OFS_LEN: len_q <= (wr_data[LW-1:0] == '0) ? LW'(1) : wr_data[LW-1:0];
        rts_pkg::OFS_PRE: pre_q <= wr_data[LW-1:0];
        rts_pkg::OFS_INT_EN: ien_q <= wr_data[rts_pkg::NEV-1:0];
        default: ; // other offsets hold nothing writable
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= rts_pkg::ST_IDLE;
    end else begin
      case (state_q)
        rts_pkg::ST_IDLE: begin
          if (start_p) begin
            // start enters measuring; capture may wait for a trigger
            if (free_run || tim_q == rts_pkg::TIM_STOP) begin
              state_q <= rts_pkg::ST_REC;
            end else begin
              state_q <= rts_pkg::ST_PRE;
            end
          end
        end
        rts_pkg::ST_PRE: begin
          // triggers are not looked at here
          if (stop_p) begin
            state_q <= rts_pkg::ST_IDLE;
          end else if (cnt_q >= pre_q) begin
            state_q <= rts_pkg::ST_WAIT;
          end
        end
        rts_pkg::ST_WAIT: begin
          if (stop_p) begin
            state_q <= rts_pkg::ST_IDLE;
          end else if (start_fire) begin
            state_q <= rts_pkg::ST_REC;
          end
        end
        rts_pkg::ST_REC: begin
          if (stop_p && stop_pend_q) begin
            state_q <= rts_pkg::ST_IDLE;
          end else if (rec_end) begin
            state_q <= last_rec ? rts_pkg::ST_IDLE : rts_pkg::ST_POST;
          end
        end
        rts_pkg::ST_POST: begin
          // no trigger is taken until processing completes
          if (stop_p || stop_pend_q) begin
            state_q <= rts_pkg::ST_IDLE;
          end else if (proc_done) begin
            if (free_run || tim_q == rts_pkg::TIM_STOP) begin
              state_q <= rts_pkg::ST_REC;
            end else begin
              state_q <= rts_pkg::ST_PRE;
            end
          end
        end
        default: state_q <= rts_pkg::ST_IDLE;
      endcase
    end
  end

  // first stop only arms while recording; elsewhere stop is immediate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stop_pend_q <= 1'b0;
    end else if (state_q == rts_pkg::ST_IDLE) begin
      stop_pend_q <= 1'b0;
    end else if (stop_p && state_q == rts_pkg::ST_REC) begin
      stop_pend_q <= 1'b1;
    end
  end

  // sample counter, reused for pre-trigger and recording
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (state_q == rts_pkg::ST_PRE || state_q == rts_pkg::ST_REC) begin
      cnt_q <= (rec_end || (state_q == rts_pkg::ST_PRE && cnt_q >= pre_q)) ?
               '0 : cnt_q + LW'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  // completed recordings since start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      recs_q <= '0;
    end else if (state_q == rts_pkg::ST_IDLE && start_p) begin
      recs_q <= '0;
    end else if (rec_end) begin
      recs_q <= recs_q + 14'h0001;
    end
  end

  // registered outputs follow state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_st_q <= rts_pkg::ST_IDLE;
      meas_q <= 1'b0;
      rec_q <= 1'b0;
      dead_q <= 1'b0;
    end else begin
      prev_st_q <= state_q;
      meas_q <= state_q != rts_pkg::ST_IDLE;
      rec_q <= state_q == rts_pkg::ST_REC;
      // start/stop span between start and stop trigger
      dead_q <= state_q == rts_pkg::ST_REC && ~free_run &&
                tim_q == rts_pkg::TIM_BOTH;
    end
  end

  // events from state changes, one cycle late
  assign ev[rts_pkg::EV_REC_START] = state_q == rts_pkg::ST_REC &&
                                     prev_st_q != rts_pkg::ST_REC;
  assign ev[rts_pkg::EV_REC_END] = state_q != rts_pkg::ST_REC &&
                                   prev_st_q == rts_pkg::ST_REC;
  assign ev[rts_pkg::EV_MEAS_END] = state_q == rts_pkg::ST_IDLE &&
                                    prev_st_q != rts_pkg::ST_IDLE;

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~((wr_stb && addr == rts_pkg::OFS_INT_CLR) ?
               wr_data[rts_pkg::NEV-1:0] : '0)) | ev;
    end
  end

  // level interrupt from a flop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_q & ien_q);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst || !rd_stb) begin
      rd_data <= '0;
    end else begin
      case (addr)
        rts_pkg::OFS_CTRL: rd_data <= 32'({stop_and_q, start_and_q, tim_q, mode_q, en_q});
        rts_pkg::OFS_COUNT: rd_data <= 32'(count_q);
        rts_pkg::OFS_SRC: rd_data <= 32'({stop_src_q, start_src_q});
        rts_pkg::OFS_LEN: rd_data <= 32'(len_q);
        rts_pkg::OFS_PRE: rd_data <= 32'(pre_q);
        rts_pkg::OFS_STATUS: rd_data <= (32'(stop_pend_q) << rts_pkg::STA_PEND) |
                            (32'(state_q) << rts_pkg::STA_STATE_LSB) |
                            (32'(recs_q) << rts_pkg::STA_RECS_LSB);
        rts_pkg::OFS_INT_STAT: rd_data <= 32'(ist_q);
        rts_pkg::OFS_INT_EN: rd_data <= 32'(ien_q);
        default: rd_data <= '0; // unmapped and write-only read zero
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_reset_trig_off: assert property (@(posedge clk_sys) disable iff (1'b0)
    srst |=> !en_q && tim_q == rts_pkg::TIM_START) else $error("reset settings wrong");
  a_free_start_rec: assert property (state_q == rts_pkg::ST_IDLE && start_p && free_run
    |=> state_q == rts_pkg::ST_REC ##1 rec_q) else $error("free run not recording");
  a_single_stops: assert property (rec_end && mode_q == rts_pkg::MODE_SINGLE
    |=> state_q == rts_pkg::ST_IDLE ##1 !meas_q) else $error("single did not stop");
  a_repeat_rearms: assert property (rec_end && mode_q == rts_pkg::MODE_REPEAT && en_q &&
    !stop_pend_q && !stop_p |=> state_q == rts_pkg::ST_POST) else $error("repeat no rearm");
  a_count_range: assert property (count_q >= rts_pkg::COUNT_MIN && count_q <= rts_pkg::COUNT_MAX)
    else $error("count out of range");
  a_count_done: assert property (rec_end && en_q && mode_q == rts_pkg::MODE_COUNT &&
    recs_q + 14'h0001 == count_q |=> state_q == rts_pkg::ST_IDLE) else $error("count overran");
  a_post_holds: assert property (state_q == rts_pkg::ST_POST && !proc_done && !stop_p &&
    !stop_pend_q |=> state_q == rts_pkg::ST_POST) else $error("left post early");
  a_second_stop: assert property (stop_pend_q && stop_p && state_q != rts_pkg::ST_IDLE
    |=> state_q == rts_pkg::ST_IDLE) else $error("second stop ignored");
  a_pre_quiet: assert property (state_q == rts_pkg::ST_PRE
    |=> state_q != rts_pkg::ST_REC) else $error("trigger in pre wait");
  a_no_intv_stop: assert property (!stop_mask[INTV_SRC]) else $error("interval as stop");
  a_full_length: assert property (state_q == rts_pkg::ST_REC && cnt_q == len_q - LW'(1)
    |=> state_q != rts_pkg::ST_REC) else $error("length overrun");
  c_repeat_cycle: cover property (state_q == rts_pkg::ST_POST ##[1:50] state_q == rts_pkg::ST_PRE);
  c_two_stops: cover property (stop_pend_q && stop_p);
  c_stop_trig: cover property (rec_end && stop_fire && tim_q == rts_pkg::TIM_STOP);
endmodule : rts_top

// ### hw/rts_pkg.sv
// Summary of operation
// - trigger function off after reset
// - no sources enabled: start records at once
// - single: one trigger, one recording, stop
// - repeat: rearm after each recording until stop
// - count mode, count clamped 2 to 10000
// - repeat: triggers ignored during post processing
// - first stop finishes recording, second stops now
// - start measures; capture waits for trigger, except stop timing records at once
// - timing start, stop or both; default start
// - interval source never acts as stop
// - no stop trigger: stop after full length
// - stop timing: single ends, repeat restarts
// - start/stop: wait start; span is dead time
// - combining uses only enabled sources
// - or combining fires on rising edge only
// - and combining fires while all hold
// - pre-trigger wait ignores triggers
package rts_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SRC = 8'h08;
  localparam logic [7:0] OFS_LEN = 8'h0C;
  localparam logic [7:0] OFS_PRE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_CLR = 8'h1C;
  localparam logic [7:0] OFS_INT_EN = 8'h20;
  // control field positions
  localparam int CTL_EN = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_TIM_LSB = 3;
  localparam int CTL_START_AND = 5;
  localparam int CTL_STOP_AND = 6;
  // source field positions
  localparam int SRC_STOP_LSB = 8;
  // status field positions
  localparam int STA_RECS_LSB = 0;
  localparam int STA_STATE_LSB = 16;
  localparam int STA_PEND = 20;
  // mode encodings
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_COUNT = 2'h2;
  // timing encodings
  localparam logic [1:0] TIM_START = 2'h0;
  localparam logic [1:0] TIM_STOP = 2'h1;
  localparam logic [1:0] TIM_BOTH = 2'h2;
  // reset values
  localparam logic RST_EN = 1'b0;
  localparam logic [1:0] RST_MODE = MODE_REPEAT;
  localparam logic [1:0] RST_TIM = TIM_START;
  localparam logic [13:0] RST_COUNT = 14'h0002;
  localparam logic [15:0] RST_LEN = 16'h0400;
  localparam logic [15:0] RST_PRE = 16'h0000;
  // count limits
  localparam logic [13:0] COUNT_MIN = 14'h0002;
  localparam logic [13:0] COUNT_MAX = 14'h2710;
  // interrupt event bits
  localparam int EV_REC_START = 0;
  localparam int EV_REC_END = 1;
  localparam int EV_MEAS_END = 2;
  localparam int NEV = 3;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_WAIT, ST_REC, ST_POST
  } rts_state_t;
endpackage : rts_pkg

// ### hw/rts_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the clock domain
module rts_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by second stage
  // both stages clear on reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : rts_sync

// ### hw/rts_comb.sv
`timescale 1ns/100ps
// and/or combiner of source conditions, one per start or stop path
module rts_comb #(
  parameter int N = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [N-1:0] cond,
  input wire logic [N-1:0] mask,
  input wire logic use_and,
  output logic fire
);
  logic [N-1:0] prev_q; // last condition levels, tracked always
  // prev tracks continuously so a level already high at start is no edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_q <= '0;
    end else begin
      prev_q <= cond;
    end
  end
  // disabled sources neither block and nor feed or
  always_comb begin
    if (mask == '0) begin
      fire = 1'b0;
    end else if (use_and) begin
      fire = &(cond | ~mask);
    end else begin
      fire = |(cond & ~prev_q & mask);
    end
  end
endmodule : rts_comb

// ### tb/rts_far_model.sv
`timescale 1ns/100ps
// far side of the sequencer: source detectors, operator keys, post processing
module rts_far_model (
  input wire logic clk_sys,
  input wire logic rec_q, // capture enable seen from the recorder
  output logic [7:0] src_cond, // condition levels, bit 7 the interval source
  output logic start_key,
  output logic stop_key,
  output logic proc_done
);
  int pd_wait = 3; // cycles from end of capture to done, bench may slow it
  int pd_cnt = 0; // post processing countdown
  logic rec_d = 1'h0; // capture enable one cycle ago
  // keys released, no condition satisfied at power up
  initial begin
    src_cond = 8'h00;
    start_key = 1'h0;
    stop_key = 1'h0;
    proc_done = 1'h0;
  end
  // post processing starts when capture ends; done is a one-cycle pulse
  always @(posedge clk_sys) begin
    rec_d <= rec_q;
    proc_done <= 1'h0;
    if (rec_d && !rec_q) begin
      pd_cnt <= pd_wait;
    end else if (pd_cnt != 0) begin
      pd_cnt <= pd_cnt - 1;
      proc_done <= (pd_cnt == 1);
    end
  end
  // one key press, held long enough to pass the synchroniser
  task automatic press(input logic is_stop);
    @(posedge clk_sys);
    if (is_stop) begin
      stop_key <= 1'h1;
    end else begin
      start_key <= 1'h1;
    end
    repeat (4) @(posedge clk_sys);
    start_key <= 1'h0;
    stop_key <= 1'h0;
    repeat (4) @(posedge clk_sys);
  endtask : press
  // new condition levels, changed just after an edge
  task automatic set_cond(input logic [7:0] v);
    @(posedge clk_sys);
    src_cond <= v;
  endtask : set_cond
endmodule : rts_far_model

// ### tb/test_recorder_trigger_sequencer.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error at %0t: value mismatch", $time); end end
// self-checking bench for the trigger sequencer
module test_recorder_trigger_sequencer;
  logic clk_sys;
  logic srst;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rd_data;
  logic [7:0] src_cond;
  logic start_key, stop_key, proc_done, meas_q, rec_q, dead_q, irq;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0; // hang guard
  int run = 0; // length of the capture in progress
  int last_len = 0; // length of the last finished capture
  int nrec = 0; // finished captures so far
  logic [31:0] v;
  int len, n0, k;
  logic [7:0] offs [8] = '{rts_pkg::OFS_CTRL, rts_pkg::OFS_COUNT, rts_pkg::OFS_SRC,
    rts_pkg::OFS_LEN, rts_pkg::OFS_PRE, rts_pkg::OFS_INT_EN, rts_pkg::OFS_INT_STAT, 8'h24};
  logic [31:0] exps [8];
  logic [31:0] cnts [4] = '{32'h1, 32'h2, 32'h2710, 32'h3FFF};
  rts_top i_dut (.clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .src_cond(src_cond),
    .start_key(start_key), .stop_key(stop_key), .proc_done(proc_done), .meas_q(meas_q),
    .rec_q(rec_q), .dead_q(dead_q), .irq(irq));
  rts_far_model i_far (.clk_sys(clk_sys), .rec_q(rec_q), .src_cond(src_cond),
    .start_key(start_key), .stop_key(stop_key), .proc_done(proc_done));
  // 100 MHz
  always #5 clk_sys = ~clk_sys;
  // measure each capture from the outside
  always @(posedge clk_sys) begin
    if (rec_q === 1'h1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
      nrec <= nrec + 1;
    end
  end
  // expected control word
  function automatic logic [31:0] ctrl(input logic en, input logic [1:0] mode,
    input logic [1:0] tim, input logic sand);
    ctrl = 32'h0;
    ctrl[rts_pkg::CTL_EN] = en;
    ctrl[rts_pkg::CTL_MODE_LSB +: 2] = mode;
    ctrl[rts_pkg::CTL_TIM_LSB +: 2] = tim;
    ctrl[rts_pkg::CTL_START_AND] = sand;
  endfunction : ctrl
  // count value after clamping to the legal span
  function automatic logic [31:0] exp_count(input logic [31:0] w);
    if (w < 32'(rts_pkg::COUNT_MIN)) return 32'(rts_pkg::COUNT_MIN);
    if (w > 32'(rts_pkg::COUNT_MAX)) return 32'(rts_pkg::COUNT_MAX);
    return w;
  endfunction : exp_count
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'h1;
    @(posedge clk_sys);
    wr_stb <= 1'h0;
  endtask : wr
  // one-cycle register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= $urandom; // noise on write data must not land on a read
    rd_stb <= 1'h1;
    @(posedge clk_sys);
    rd_stb <= 1'h0;
    #1 d = rd_data;
  endtask : rd
  // bounded wait: 0 idle, 1 capturing, 2 not capturing, 3 capture count reached
  task automatic wait_for(input int what, input int target);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      if (what == 0 && meas_q === 1'h0) break;
      if (what == 1 && rec_q === 1'h1) break;
      if (what == 2 && rec_q === 1'h0) break;
      if (what == 3 && nrec >= target) break;
    end
    if (i == 3000) begin
      fail_count++;
      $display("Error at %0t: wait expired", $time);
    end
    repeat (2) @(posedge clk_sys);
  endtask : wait_for
  // verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // cut a hang short well beyond the expected thousand or so cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    clk_sys = 1'h0; // idle levels before the first edge
    srst = 1'h1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    exps = '{ctrl(rts_pkg::RST_EN, rts_pkg::RST_MODE, rts_pkg::RST_TIM, 1'h0),
      32'(rts_pkg::RST_COUNT), 32'h0, 32'(rts_pkg::RST_LEN), 32'(rts_pkg::RST_PRE),
      32'h0, 32'h0, 32'h0};
    void'($urandom(49119));
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    // reset settings, unmapped address reads zero
    foreach (offs[i]) begin
      rd(offs[i], v);
      `CHK(v, exps[i])
    end
    // count clamped at both ends
    foreach (cnts[i]) begin
      wr(rts_pkg::OFS_COUNT, cnts[i]);
      rd(rts_pkg::OFS_COUNT, v);
      `CHK(v, exp_count(cnts[i]))
    end
    // trigger off: one free recording of random length despite repeat mode
    len = 2 + $urandom % 19;
    wr(rts_pkg::OFS_LEN, 32'(len));
    wr(rts_pkg::OFS_INT_EN, 32'h7);
    n0 = nrec;
    i_far.press(1'h0);
    wait_for(0, 0);
    `CHK(last_len, len)
    `CHK(nrec, n0 + 1)
    `CHK(irq, 1'h1)
    rd(rts_pkg::OFS_INT_STAT, v);
    `CHK(v, 32'h7)
    wr(rts_pkg::OFS_INT_EN, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'h0)
    wr(rts_pkg::OFS_INT_EN, 32'h7);
    wr(rts_pkg::OFS_INT_CLR, 32'h7);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'h0)
    // repeat free run, then one stop and a double stop
    wr(rts_pkg::OFS_LEN, 32'h28);
    wr(rts_pkg::OFS_CTRL, ctrl(1'h1, rts_pkg::MODE_REPEAT, rts_pkg::TIM_START, 1'h0));
    n0 = nrec;
    i_far.press(1'h0);
    wait_for(3, n0 + 3);
    `CHK(meas_q, 1'h1)
    wait_for(1, 0);
    i_far.press(1'h1);
    wait_for(0, 0);
    `CHK(last_len, 40)
    i_far.press(1'h0);
    wait_for(1, 0);
    i_far.press(1'h1);
    i_far.press(1'h1);
    wait_for(0, 0);
    `CHK((last_len < 40), 1'h1)
    // or combining: level held at start does not fire, edge does
    wr(rts_pkg::OFS_SRC, 32'h1);
    i_far.set_cond(8'h01);
    n0 = nrec;
    i_far.press(1'h0);
    repeat (30) @(posedge clk_sys);
    `CHK(nrec, n0)
    i_far.set_cond(8'h00);
    repeat (4) @(posedge clk_sys);
    i_far.set_cond(8'h01);
    i_far.pd_wait = 40;
    wait_for(1, 0);
    wait_for(2, 0);
    // edge during slow post processing is lost
    i_far.set_cond(8'h00);
    repeat (4) @(posedge clk_sys);
    i_far.set_cond(8'h01);
    repeat (4) @(posedge clk_sys);
    i_far.set_cond(8'h00);
    repeat (60) @(posedge clk_sys);
    `CHK(nrec, n0 + 1)
    i_far.press(1'h1);
    wait_for(0, 0);
    i_far.pd_wait = 3;
    // edge during the pre-trigger wait is lost
    wr(rts_pkg::OFS_PRE, 32'h1E);
    n0 = nrec;
    i_far.press(1'h0);
    i_far.set_cond(8'h01);
    repeat (60) @(posedge clk_sys);
    `CHK(nrec, n0)
    i_far.press(1'h1);
    wait_for(0, 0);
    wr(rts_pkg::OFS_PRE, 32'h0);
    // and combining in single mode: held levels fire, disabled sources ignored
    wr(rts_pkg::OFS_CTRL, ctrl(1'h1, rts_pkg::MODE_SINGLE, rts_pkg::TIM_START, 1'h1));
    i_far.set_cond({7'($urandom), 1'h1}); // random levels on disabled sources
    n0 = nrec;
    i_far.press(1'h0);
    wait_for(0, 0);
    `CHK(nrec, n0 + 1)
    // count mode, two recordings then stop
    i_far.set_cond(8'h00);
    wr(rts_pkg::OFS_COUNT, 32'h2);
    wr(rts_pkg::OFS_CTRL, ctrl(1'h1, rts_pkg::MODE_COUNT, rts_pkg::TIM_START, 1'h0));
    n0 = nrec;
    i_far.press(1'h0);
    for (k = 0; k < 2; k++) begin
      i_far.set_cond(8'h01);
      wait_for(1, 0);
      i_far.set_cond(8'h00);
      wait_for(2, 0);
      repeat (10) @(posedge clk_sys);
    end
    wait_for(0, 0);
    `CHK(nrec, n0 + 2)
    rd(rts_pkg::OFS_STATUS, v);
    `CHK(v, 32'h2 << rts_pkg::STA_RECS_LSB)
    // stop timing: full length without a stop, early with one; interval never stops
    wr(rts_pkg::OFS_SRC, 32'h8100);
    wr(rts_pkg::OFS_CTRL, ctrl(1'h1, rts_pkg::MODE_SINGLE, rts_pkg::TIM_STOP, 1'h0));
    for (k = 0; k < 2; k++) begin
      i_far.press(1'h0);
      i_far.set_cond(8'h80);
      repeat (6) @(posedge clk_sys);
      `CHK(dead_q, 1'h0)
      if (k == 1) i_far.set_cond(8'h81);
      wait_for(0, 0);
      `CHK((last_len == 40), (k == 0))
      i_far.set_cond(8'h00);
      repeat (4) @(posedge clk_sys);
    end
    // start/stop timing: dead span between start and stop triggers
    wr(rts_pkg::OFS_SRC, 32'h0201);
    wr(rts_pkg::OFS_CTRL, ctrl(1'h1, rts_pkg::MODE_SINGLE, rts_pkg::TIM_BOTH, 1'h0));
    i_far.press(1'h0);
    repeat (5) @(posedge clk_sys);
    `CHK(rec_q, 1'h0)
    i_far.set_cond(8'h01);
    wait_for(1, 0);
    `CHK(dead_q, 1'h1)
    i_far.set_cond(8'h03);
    wait_for(0, 0);
    `CHK((last_len < 40), 1'h1)
    report_and_stop();
  end
endmodule : test_recorder_trigger_sequencer
